// [lbpc_core.sv]
// Pipeline control for one processor on the local bus: stage decode,
// interlocks, refill and cache-miss sequencing, address and data drive.
// Assumes wired lines are resolved outside (pull-up plus enables).
//
// Contract
// - Upstream advance without downstream advance is illegal
// - Decode kill, hold, load per stage
// - Abort kills all four stages
// - Cache miss holds all four stages
// - Kill writeback before release if memory follows
// - Refill kills access stage, fetch/ALU held
// - Interlock kills ALU stage
// - Interrupt qualified by permit every cycle
// - Kernel bit tracked, blocks interrupt
// - Stage ownership of external buses
// - Opcodes decoded into three classes
// - Store reads in access, writes in writeback
// - Memory after store kills ALU once
// - Refill pair, second inverts address bit 3
// - Store in access gets null before refill
// - Line cross or jump extends refill hold; the code extends it only on ibuf_cross, with no jump input
// - Held writeback keeps driving its address
// - Address always driven, bit 3 inverted while alternate select is high
// - Line moves as alternate then requested half
// - Data captured every cycle, written next cycle
// - One extra held cycle after requested half
// - CPU drives one selected data half
// - Advance lines wired, pulled low for false
// - Permit dropped during cache-miss sequences
//
`timescale 1ns/100ps
module lbpc_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Wired stage advance lines
    input wire lbpc_pkg::lbpc_loads_t load_line_in,
    output lbpc_pkg::lbpc_loads_t load_line_out,
    output lbpc_pkg::lbpc_loads_t load_line_oe,
    // Wired low-true interrupt and its permit
    input wire logic interrupt_n_in,
    output logic interrupt_n_out,
    output logic interrupt_n_oe,
    output logic interrupt_permit,
    // Fetch stage bus outputs
    output logic kernel_out,
    output logic [3:0] opcode_bus,
    output logic [5:0] register_bus,
    // Address bus
    output logic [31:0] address_bus,
    output logic instruction_fetch_flag,
    output logic alternate_doubleword_select,
    // Data bus
    input wire logic [63:0] data_in,
    output logic [63:0] data_out,
    output logic [1:0] data_oe,
    // Memory controller
    input wire logic mem_data_ready,
    // Core side requests
    input wire logic [3:0] fetch_opcode,
    input wire logic [5:0] fetch_reg,
    input wire logic fetch_kernel,
    input wire logic [31:0] fetch_pc,
    input wire logic [31:0] alu_addr,
    input wire logic [31:0] alu_store_data,
    input wire logic trap_req,
    input wire logic interlock_req,
    input wire logic ibuf_miss,
    input wire logic ibuf_cross,
    input wire logic cache_miss,
    // Core side results
    output lbpc_pkg::lbpc_act_t act_if,
    output lbpc_pkg::lbpc_act_t act_alu,
    output lbpc_pkg::lbpc_act_t act_mem,
    output lbpc_pkg::lbpc_act_t act_wb,
    output logic pipe_illegal,
    output logic wb_write,
    output logic wb_to_ibuf,
    output logic [63:0] wb_data
);

    function automatic lbpc_pkg::lbpc_class_t op_class(input logic [3:0] op);
        lbpc_pkg::lbpc_class_t c;
        c = lbpc_pkg::CLS_NONE;
        case (op)
            lbpc_pkg::OP_COP_TO_CPU, lbpc_pkg::OP_COP_LOAD,
            lbpc_pkg::OP_CPU_LOAD, lbpc_pkg::OP_COP_ALU: c = lbpc_pkg::CLS_LOAD;
            lbpc_pkg::OP_CPU_TO_COP, lbpc_pkg::OP_COP_STORE,
            lbpc_pkg::OP_CPU_STORE: c = lbpc_pkg::CLS_STORE;
            default: c = lbpc_pkg::CLS_NONE;
        endcase
        return c;
    endfunction

    function automatic logic is_mem(input lbpc_pkg::lbpc_stage_t s);
        return s.valid && (s.ifetch || op_class(s.opcode) != lbpc_pkg::CLS_NONE);
    endfunction

    function automatic logic is_store(input lbpc_pkg::lbpc_stage_t s);
        return s.valid && !s.ifetch && op_class(s.opcode) == lbpc_pkg::CLS_STORE;
    endfunction

    // Illegal up-without-own combination is treated as hold
    function automatic lbpc_pkg::lbpc_act_t stage_act(input logic abort, input logic up, input logic own);
        lbpc_pkg::lbpc_act_t a;
        if (abort)
            a = lbpc_pkg::ACT_KILL;
        else if (!own)
            a = lbpc_pkg::ACT_HOLD;
        else if (!up)
            a = lbpc_pkg::ACT_KILL;
        else
            a = lbpc_pkg::ACT_LOAD;
        return a;
    endfunction

    function automatic lbpc_pkg::lbpc_stage_t stage_next(input lbpc_pkg::lbpc_act_t a,
        input lbpc_pkg::lbpc_stage_t cur, input lbpc_pkg::lbpc_stage_t up, input lbpc_pkg::lbpc_stage_t dead);
        lbpc_pkg::lbpc_stage_t n;
        case (a)
            lbpc_pkg::ACT_LOAD: n = up;
            lbpc_pkg::ACT_HOLD: n = cur;
            default: n = dead;
        endcase
        return n;
    endfunction

    // Pin synchronisers
    lbpc_pkg::lbpc_loads_t ld_s1_r, ld_s2_r;
    logic int_n_s1_r, int_n_s2_r;
    logic mrdy_s1_r, mrdy_s2_r;
    logic [63:0] data_s1_r, data_s2_r, data_lat_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ld_s1_r <= lbpc_pkg::LD_SYNC_RESET;
            ld_s2_r <= lbpc_pkg::LD_SYNC_RESET;
            int_n_s1_r <= lbpc_pkg::INT_N_SYNC_RESET;
            int_n_s2_r <= lbpc_pkg::INT_N_SYNC_RESET;
            mrdy_s1_r <= 1'b0;
            mrdy_s2_r <= 1'b0;
            data_s1_r <= lbpc_pkg::DATA_RESET;
            data_s2_r <= lbpc_pkg::DATA_RESET;
            data_lat_r <= lbpc_pkg::DATA_RESET;
        end
        else
        begin
            ld_s1_r <= load_line_in;
            ld_s2_r <= ld_s1_r;
            int_n_s1_r <= interrupt_n_in;
            int_n_s2_r <= int_n_s1_r;
            mrdy_s1_r <= mem_data_ready;
            mrdy_s2_r <= mrdy_s1_r;
            data_s1_r <= data_in;
            data_s2_r <= data_s1_r;
            data_lat_r <= data_s2_r;
        end
    end

    // Stage and sequencer state
    lbpc_pkg::lbpc_stage_t alu_r, mem_r, wb_r, alu_nxt, mem_nxt, wb_nxt;
    lbpc_pkg::lbpc_miss_t miss_r, miss_nxt;
    lbpc_pkg::lbpc_ibuf_t ib_r, ib_nxt;
    logic cross_r, cross_nxt;

    // Requested advance patterns, combined as the wire would
    wire logic wb_load = is_mem(wb_r) && !is_store(wb_r) && !wb_r.ifetch;
    wire logic miss_now = (miss_r == lbpc_pkg::M_IDLE) && cache_miss && wb_load;
    wire logic store_follow = is_store(alu_r) && op_class(fetch_opcode) != lbpc_pkg::CLS_NONE;
    wire logic [3:0] want_cpu = (ib_r != lbpc_pkg::I_IDLE) ? lbpc_pkg::LD_KILL_MEM
        : (store_follow || interlock_req) ? lbpc_pkg::LD_KILL_ALU
        : lbpc_pkg::LD_NORMAL;
    wire logic [3:0] want_ccu = miss_now ? lbpc_pkg::LD_HOLD_ALL
        : (miss_r == lbpc_pkg::M_IDLE) ? lbpc_pkg::LD_NORMAL
        : (miss_r == lbpc_pkg::M_KILLWB) ? lbpc_pkg::LD_KILL_WB
        : lbpc_pkg::LD_HOLD_ALL;
    // Both patterns are monotonic, so their AND never makes the illegal case
    wire logic [3:0] want = want_cpu & want_ccu;
    // Own pulls act at once; synced lines add the other chips' pulls and repeat own pulls two cycles later
    wire lbpc_pkg::lbpc_loads_t eff_line = lbpc_pkg::lbpc_loads_t'(ld_s2_r & want);

    // Stage decode from the resolved lines
    wire logic abort = interrupt_permit && !int_n_s2_r;
    assign act_if = stage_act(abort, 1'b1, eff_line.lif);
    assign act_alu = stage_act(abort, eff_line.lif, eff_line.lalu);
    assign act_mem = stage_act(abort, eff_line.lalu, eff_line.lmem);
    assign act_wb = stage_act(abort, eff_line.lmem, eff_line.lwb);
    assign pipe_illegal = (ld_s2_r.lif && !ld_s2_r.lalu) || (ld_s2_r.lalu && !ld_s2_r.lmem)
        || (ld_s2_r.lmem && !ld_s2_r.lwb);

    // Instruction entering ALU from fetch
    wire lbpc_pkg::lbpc_stage_t fetch_ins = '{valid: 1'b1, kernel: fetch_kernel, ifetch: 1'b0,
        opcode: fetch_opcode, regnum: fetch_reg, addr: 32'h0000_0000, sdata: 32'h0000_0000};
    // Coprocessor ALU op travels on the address bus as itself
    wire logic [31:0] alu_eff_addr = (alu_r.opcode == lbpc_pkg::OP_COP_ALU)
        ? {22'h00_0000, alu_r.regnum, alu_r.opcode} : alu_addr;
    wire lbpc_pkg::lbpc_stage_t alu_out = '{valid: alu_r.valid, kernel: alu_r.kernel, ifetch: 1'b0,
        opcode: alu_r.opcode, regnum: alu_r.regnum, addr: alu_eff_addr, sdata: alu_store_data};
    // Refill pseudo-instruction, addressed by the fetch PC
    wire lbpc_pkg::lbpc_stage_t pseudo_ins = '{valid: 1'b1, kernel: 1'b0, ifetch: 1'b1,
        opcode: lbpc_pkg::OP_CPU_LOAD, regnum: {5'h00, ib_r == lbpc_pkg::I_REF2}, addr: fetch_pc,
        sdata: 32'h0000_0000};
    wire logic ib_ref = (ib_r == lbpc_pkg::I_REF1) || (ib_r == lbpc_pkg::I_REF2);
    wire lbpc_pkg::lbpc_stage_t mem_dead = (ib_ref && !abort) ? pseudo_ins : '0;

    assign alu_nxt = stage_next(act_alu, alu_r, fetch_ins, '0);
    assign mem_nxt = stage_next(act_mem, mem_r, alu_out, mem_dead);
    assign wb_nxt = stage_next(act_wb, wb_r, mem_r, '0);

    // Refill sequencer; leaves its final hold state only when the pipe is not frozen
    wire logic pipe_moves = !abort && eff_line.lwb;
    // Refill steps once its pseudo really entered the access stage
    wire logic mem_killed = (act_mem == lbpc_pkg::ACT_KILL);

    always_comb
    begin
        ib_nxt = ib_r;
        cross_nxt = cross_r;
        if (abort)
            ib_nxt = lbpc_pkg::I_IDLE;
        else
        begin
            case (ib_r)
                lbpc_pkg::I_IDLE:
                    if (ibuf_miss)
                    begin
                        cross_nxt = ibuf_cross;
                        ib_nxt = is_store(mem_r) ? lbpc_pkg::I_NULL : lbpc_pkg::I_REF1;
                    end
                lbpc_pkg::I_NULL:
                    if (mem_killed)
                        ib_nxt = lbpc_pkg::I_REF1;
                lbpc_pkg::I_REF1:
                    if (mem_killed)
                        ib_nxt = lbpc_pkg::I_REF2;
                lbpc_pkg::I_REF2:
                    if (mem_killed)
                        ib_nxt = cross_r ? lbpc_pkg::I_HOLD : lbpc_pkg::I_IDLE;
                lbpc_pkg::I_HOLD:
                    if (pipe_moves)
                        ib_nxt = lbpc_pkg::I_IDLE;
                default: ib_nxt = lbpc_pkg::I_IDLE;
            endcase
        end
    end

    // Cache miss sequencer
    always_comb
    begin
        miss_nxt = miss_r;
        case (miss_r)
            lbpc_pkg::M_IDLE:
                if (miss_now)
                    miss_nxt = lbpc_pkg::M_WAIT;
            lbpc_pkg::M_WAIT:
                if (mrdy_s2_r)
                    miss_nxt = lbpc_pkg::M_ALT;
            lbpc_pkg::M_ALT: miss_nxt = lbpc_pkg::M_REQ;
            lbpc_pkg::M_REQ: miss_nxt = lbpc_pkg::M_LAST;
            lbpc_pkg::M_LAST: miss_nxt = is_mem(mem_r) ? lbpc_pkg::M_KILLWB : lbpc_pkg::M_IDLE;
            lbpc_pkg::M_KILLWB: miss_nxt = lbpc_pkg::M_IDLE;
            default: miss_nxt = lbpc_pkg::M_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            alu_r <= '0;
            mem_r <= '0;
            wb_r <= '0;
            miss_r <= lbpc_pkg::M_IDLE;
            ib_r <= lbpc_pkg::I_IDLE;
            cross_r <= 1'b0;
        end
        else
        begin
            alu_r <= alu_nxt;
            mem_r <= mem_nxt;
            wb_r <= wb_nxt;
            miss_r <= miss_nxt;
            ib_r <= ib_nxt;
            cross_r <= cross_nxt;
        end
    end

    assign load_line_out = '0;
    assign load_line_oe = ~want;

    // Interrupt drive and permit
    wire logic any_kernel = fetch_kernel || (alu_r.valid && alu_r.kernel) || (mem_r.valid && mem_r.kernel)
        || (wb_r.valid && wb_r.kernel);
    assign interrupt_n_out = 1'b0;
    assign interrupt_n_oe = trap_req && !any_kernel;
    assign interrupt_permit = (miss_r == lbpc_pkg::M_IDLE) && !miss_now;

    // Fetch stage bus outputs
    assign kernel_out = fetch_kernel;
    assign opcode_bus = fetch_opcode;
    assign register_bus = fetch_reg;

    // Address: writeback store or held load wins over access stage
    wire logic wb_addr_own = is_store(wb_r) || (wb_load && (miss_r != lbpc_pkg::M_IDLE || miss_now));
    wire logic mem_addr_own = is_mem(mem_r);
    wire logic [31:0] addr_sel = wb_addr_own ? wb_r.addr : mem_addr_own ? mem_r.addr : 32'h0000_0000;
    // Second refill pseudo carries its mark in the register field
    assign alternate_doubleword_select = (miss_r == lbpc_pkg::M_ALT)
        || (mem_r.valid && mem_r.ifetch && mem_r.regnum[0]);
    always_comb
    begin
        address_bus = addr_sel;
        address_bus[lbpc_pkg::ADDR_ALT_BIT] = addr_sel[lbpc_pkg::ADDR_ALT_BIT]
            ^ alternate_doubleword_select;
    end
    assign instruction_fetch_flag = !wb_addr_own && mem_addr_own && mem_r.ifetch;

    // Data: only writeback stores drive, one half at a time
    wire logic drive_ok = is_store(wb_r) && (miss_r == lbpc_pkg::M_IDLE);
    wire logic half_hi = (wb_r.opcode == lbpc_pkg::OP_CPU_TO_COP) || wb_r.addr[lbpc_pkg::ADDR_HALF_BIT];
    wire logic cpu_drives = drive_ok && (wb_r.opcode != lbpc_pkg::OP_COP_STORE);
    assign data_out = {wb_r.sdata, wb_r.sdata};
    assign data_oe = {cpu_drives && half_hi, cpu_drives && !half_hi};

    // Writeback repeats while held, so the last held cycle takes fresh data
    assign wb_write = wb_r.valid && (wb_r.ifetch || wb_r.opcode == lbpc_pkg::OP_CPU_LOAD
        || wb_r.opcode == lbpc_pkg::OP_COP_TO_CPU);
    assign wb_to_ibuf = wb_r.valid && wb_r.ifetch;
    assign wb_data = data_lat_r;

endmodule

// [lbpc_pkg.sv]
// Shared constants and types for the local bus pipeline control block.
// Assumes one core clock; all users refer to items as lbpc_pkg::name.
package lbpc_pkg;

    // Opcode encodings (thirteen opcodes, 0xD..0xF undefined)
    localparam logic [3:0] OP_TRAP = 4'h0;
    localparam logic [3:0] OP_EXTRACT0 = 4'h1;
    localparam logic [3:0] OP_EXTRACT1 = 4'h2;
    localparam logic [3:0] OP_CPU_ALU = 4'h3;
    localparam logic [3:0] OP_COND_JUMP = 4'h4;
    localparam logic [3:0] OP_ADD_IMM = 4'h5;
    localparam logic [3:0] OP_COP_TO_CPU = 4'h6;
    localparam logic [3:0] OP_COP_LOAD = 4'h7;
    localparam logic [3:0] OP_CPU_LOAD = 4'h8;
    localparam logic [3:0] OP_COP_ALU = 4'h9;
    localparam logic [3:0] OP_CPU_TO_COP = 4'hA;
    localparam logic [3:0] OP_COP_STORE = 4'hB;
    localparam logic [3:0] OP_CPU_STORE = 4'hC;

    // Address bit positions
    localparam int ADDR_ALT_BIT = 3;
    localparam int ADDR_HALF_BIT = 2;

    // Stage advance patterns {if, alu, mem, wb}
    localparam logic [3:0] LD_NORMAL = 4'hF;
    localparam logic [3:0] LD_KILL_ALU = 4'h7;
    localparam logic [3:0] LD_KILL_MEM = 4'h3;
    localparam logic [3:0] LD_KILL_WB = 4'h1;
    localparam logic [3:0] LD_HOLD_ALL = 4'h0;

    // Reset values
    localparam logic [3:0] LD_SYNC_RESET = 4'hF;
    localparam logic INT_N_SYNC_RESET = 1'b1;
    localparam logic [63:0] DATA_RESET = 64'h0000_0000_0000_0000;

    typedef enum logic [2:0] {CLS_NONE = 3'h1, CLS_LOAD = 3'h2, CLS_STORE = 3'h4} lbpc_class_t;
    typedef enum logic [2:0] {ACT_HOLD = 3'h1, ACT_KILL = 3'h2, ACT_LOAD = 3'h4} lbpc_act_t;

    typedef enum logic [5:0] {
        M_IDLE = 6'h01, M_WAIT = 6'h02, M_ALT = 6'h04, M_REQ = 6'h08, M_LAST = 6'h10, M_KILLWB = 6'h20
    } lbpc_miss_t;

    typedef enum logic [4:0] {
        I_IDLE = 5'h01, I_NULL = 5'h02, I_REF1 = 5'h04, I_REF2 = 5'h08, I_HOLD = 5'h10
    } lbpc_ibuf_t;

    typedef struct packed {
        logic lif;
        logic lalu;
        logic lmem;
        logic lwb;
    } lbpc_loads_t;

    typedef struct packed {
        logic valid;
        logic kernel;
        logic ifetch;
        logic [3:0] opcode;
        logic [5:0] regnum;
        logic [31:0] addr;
        logic [31:0] sdata;
    } lbpc_stage_t;

endpackage

// [lbpc_core_properties.sv]
// Port-level checks for the local bus pipeline control block.
// Assumes one clock domain; bound onto every lbpc_core instance.
`timescale 1ns/100ps
module lbpc_core_properties (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Wired lines and permit
    input wire lbpc_pkg::lbpc_loads_t load_line_in,
    input wire lbpc_pkg::lbpc_loads_t load_line_oe,
    input wire logic interrupt_n_in,
    input wire logic interrupt_n_out,
    input wire logic interrupt_n_oe,
    input wire logic interrupt_permit,
    input wire logic kernel_out,
    input wire logic alternate_doubleword_select,
    // Data
    input wire logic [63:0] data_in,
    input wire logic [1:0] data_oe,
    input wire logic [63:0] wb_data,
    // Stage actions
    input wire lbpc_pkg::lbpc_act_t act_if,
    input wire lbpc_pkg::lbpc_act_t act_alu,
    input wire lbpc_pkg::lbpc_act_t act_mem,
    input wire lbpc_pkg::lbpc_act_t act_wb
);
    logic [1:0] age_r;
    logic live;

    // Synchronisers still hold reset values for three edges
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            age_r <= 2'h0;
        else if (age_r != 2'h3)
            age_r <= age_r + 2'h1;
    assign live = age_r == 2'h3;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence miss_start;
        $rose(load_line_oe == 4'hF);
    endsequence
    sequence alt_half;
        alternate_doubleword_select && load_line_oe == 4'hF;
    endsequence
    sequence retire_tail;
        !alternate_doubleword_select && load_line_oe == 4'hF ##1 load_line_oe == 4'hF ##1 load_line_oe != 4'hF;
    endsequence

    oe_prefix_a: assert property (load_line_oe inside {4'h0, 4'h8, 4'hC, 4'hE, 4'hF})
        else $error("pull pattern leaves an upstream line free");
    alu_kill_a: assert property (live && $past(interrupt_n_in, 2) && $past(load_line_in.lalu, 2)
        && !$past(load_line_in.lif, 2) && !load_line_oe.lalu |-> act_alu == lbpc_pkg::ACT_KILL)
        else $error("alu stage not killed");
    wb_hold_a: assert property (live && $past(interrupt_n_in, 2) && !$past(load_line_in.lwb, 2)
        |-> act_wb == lbpc_pkg::ACT_HOLD)
        else $error("writeback stage not held");
    mem_load_a: assert property (live && $past(interrupt_n_in, 2) && $past(load_line_in.lalu, 2)
        && $past(load_line_in.lmem, 2) && !load_line_oe.lalu && !load_line_oe.lmem
        |-> act_mem == lbpc_pkg::ACT_LOAD)
        else $error("access stage not loaded");
    abort_kill_a: assert property (live && !$past(interrupt_n_in, 2) && interrupt_permit
        && $past(interrupt_permit) && $past(interrupt_permit, 2)
        |-> {act_if, act_alu, act_mem, act_wb} == {4{lbpc_pkg::ACT_KILL}})
        else $error("abort did not kill every stage");
    permit_gate_a: assert property (act_if == lbpc_pkg::ACT_KILL
        |-> interrupt_permit || $past(interrupt_permit) || $past(interrupt_permit, 2))
        else $error("kill without permit");
    kernel_int_a: assert property (interrupt_n_oe |-> !kernel_out && !interrupt_n_out)
        else $error("interrupt pulled beside a kernel instruction");
    miss_hold_a: assert property (miss_start |-> (!interrupt_permit && load_line_oe == 4'hF) [*4])
        else $error("miss hold or permit drop too short");
    half_order_a: assert property (alt_half |=> retire_tail)
        else $error("refill halves or final hold out of order");
    data_lag_a: assert property (live |-> wb_data == $past(data_in, 3))
        else $error("captured data not delivered");
    half_drive_a: assert property (data_oe != 2'h3)
        else $error("both data halves driven");
endmodule

bind lbpc_core lbpc_core_properties u_props (
    .core_clk, .rst, .load_line_in, .load_line_oe, .interrupt_n_in, .interrupt_n_out, .interrupt_n_oe,
    .interrupt_permit, .kernel_out, .alternate_doubleword_select, .data_in, .data_oe, .wb_data,
    .act_if, .act_alu, .act_mem, .act_wb
);

// [lbpc_far_end.sv]
// Other chips on the local bus: wired line resolution, cache data, memory.
// Assumes the bench gives the other chips' pulls and the memory latency.
`timescale 1ns/100ps
module lbpc_far_end (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Wired lines
    input wire lbpc_pkg::lbpc_loads_t load_line_oe,
    input wire logic [3:0] other_pull,
    output lbpc_pkg::lbpc_loads_t load_line_in,
    input wire logic interrupt_n_oe,
    input wire logic other_int,
    output logic interrupt_n_in,
    // Data bus and memory
    input wire logic [1:0] data_oe,
    input wire logic [63:0] data_out,
    input wire logic [7:0] mem_lat,
    output logic [63:0] data_in,
    output logic mem_data_ready
);
    logic [7:0] wait_r;
    logic [63:0] noise_r;

    // Pull-up: true only while nobody pulls low
    assign load_line_in = ~(load_line_oe | other_pull);
    assign interrupt_n_in = ~(interrupt_n_oe | other_int);
    // Undriven halves move every cycle so stale data cannot pass
    assign data_in[63:32] = data_oe[1] ? data_out[63:32] : noise_r[63:32];
    assign data_in[31:0] = data_oe[0] ? data_out[31:0] : noise_r[31:0];

    always_ff @(posedge core_clk or posedge rst)
        if (rst)
        begin
            wait_r <= 8'h00;
            mem_data_ready <= 1'b0;
            noise_r <= 64'h0123_4567_89AB_CDEF;
        end
        else
        begin
            noise_r <= noise_r + 64'h9E37_79B9_7F4A_7C15;
            if (load_line_oe != 4'hF)
            begin
                wait_r <= 8'h00;
                mem_data_ready <= 1'b0;
            end
            else if (wait_r == mem_lat)
                mem_data_ready <= 1'b1;
            else
                wait_r <= wait_r + 8'h01;
        end
endmodule

// [local_bus_pipeline_control_tb.sv]
// Self-checking bench for lbpc_core with the far-end model.
// Assumes the bound checker; all stimulus at rising edges.
`timescale 1ns/100ps
module local_bus_pipeline_control_tb;
    logic core_clk, rst, int_n_in, int_oe, permit, kern, ifl, alt, dready, illegal, wbw;
    logic trap, ilk, imiss, icross, cmiss, fkern, oint;
    lbpc_pkg::lbpc_loads_t line_in, oe;
    lbpc_pkg::lbpc_act_t a_if, a_alu, a_mem, a_wb;
    logic [3:0] fop, pull;
    logic [5:0] freg;
    logic [31:0] fpc, aaddr, sdata, addr;
    logic [63:0] din, dout;
    logic [1:0] doe, seen;
    logic [7:0] lat;
    int n_fail = 0;
    int n_checks = 0;
    int bad;

    lbpc_core dut (
        .core_clk, .rst, .load_line_in(line_in), .load_line_out(), .load_line_oe(oe),
        .interrupt_n_in(int_n_in), .interrupt_n_out(), .interrupt_n_oe(int_oe), .interrupt_permit(permit),
        .kernel_out(kern), .opcode_bus(), .register_bus(), .address_bus(addr),
        .instruction_fetch_flag(ifl), .alternate_doubleword_select(alt), .data_in(din), .data_out(dout),
        .data_oe(doe), .mem_data_ready(dready), .fetch_opcode(fop), .fetch_reg(freg), .fetch_kernel(fkern),
        .fetch_pc(fpc), .alu_addr(aaddr), .alu_store_data(sdata), .trap_req(trap), .interlock_req(ilk),
        .ibuf_miss(imiss), .ibuf_cross(icross), .cache_miss(cmiss), .act_if(a_if), .act_alu(a_alu),
        .act_mem(a_mem), .act_wb(a_wb), .pipe_illegal(illegal), .wb_write(wbw), .wb_to_ibuf(), .wb_data()
    );
    lbpc_far_end far (
        .core_clk, .rst, .load_line_oe(oe), .other_pull(pull), .load_line_in(line_in),
        .interrupt_n_oe(int_oe), .other_int(oint), .interrupt_n_in(int_n_in), .data_oe(doe),
        .data_out(dout), .mem_lat(lat), .data_in(din), .mem_data_ready(dready)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic lbpc_pkg::lbpc_act_t act_of(input logic up, input logic own);
        return !own ? lbpc_pkg::ACT_HOLD : (up ? lbpc_pkg::ACT_LOAD : lbpc_pkg::ACT_KILL);
    endfunction

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Samples n cycles from now, ends on an edge
    task automatic count_oe(input logic [3:0] v, input int n, output int c);
        c = 0;
        repeat (n)
        begin
            #1;
            c += int'(oe === v);
            if (ifl === 1'b1)
            begin
                seen[addr[3]] = 1'b1;
                bad += int'({addr[31:4], addr[2:0]} !== {fpc[31:4], fpc[2:0]});
            end
            @(posedge core_clk);
        end
    endtask

    task automatic results;
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #50000;
        n_fail++;
        results;
    end

    initial
    begin
        int k, c;
        int cnt[2];
        logic [31:0] a, d;
        logic [3:0] pat;
        rst = 1'b1;
        {trap, ilk, imiss, icross, cmiss, fkern, oint} = 7'h00;
        {pull, fop, freg, lat} = {4'h0, lbpc_pkg::OP_CPU_ALU, 6'h00, 8'h08};
        {fpc, aaddr, sdata} = 96'h0;
        k = $urandom(17542);
        tick(6);
        rst <= 1'b0;
        tick(3);
        // Other chips force every line combination, corners first
        for (k = 0; k < 40; k++)
        begin
            pat = k < 16 ? k[3:0] : (k == 39 ? 4'hF : 4'($urandom));
            pull <= ~pat;
            freg <= 6'($urandom);
            ilk <= k == 39;
            pat[3] = pat[3] && k != 39;
            tick(3);
            #1;
            cmp({illegal, a_if, a_alu, a_mem, a_wb}, {|(pat[3:1] & ~pat[2:0]), act_of(1'b1, pat[3]),
                act_of(pat[3], pat[2]), act_of(pat[2], pat[1]), act_of(pat[1], pat[0])});
        end
        cmp(oe, 4'h8);
        tick(1);
        ilk <= 1'b0;
        tick(4);
        {pull, ilk, fkern, trap} <= 7'h03;
        tick(1);
        fkern <= 1'b0;
        for (k = 0; k < 4; k++)
        begin
            #1;
            cmp(int_oe, k == 3);
            tick(1);
        end
        count_oe(4'h0, 5, c);
        c = 0;
        repeat (5)
        begin
            #1;
            c += int'({a_if, a_alu, a_mem, a_wb} === {4{lbpc_pkg::ACT_KILL}});
            tick(1);
        end
        cmp(c > 0, 1'b1);
        trap <= 1'b0;
        tick(4);
        // Store halves: low, high by address, high for transfer
        for (k = 0; k < 3; k++)
        begin
            a = $urandom;
            a[2] = k[0];
            d = $urandom;
            fop <= k == 2 ? lbpc_pkg::OP_CPU_TO_COP : lbpc_pkg::OP_CPU_STORE;
            {aaddr, sdata} <= {a, d};
            tick(1);
            fop <= lbpc_pkg::OP_CPU_ALU;
            c = 0;
            #1;
            while (doe === 2'h0 && c < 8)
            begin
                tick(1);
                #1;
                c++;
            end
            cmp(doe, k == 0 ? 2'h1 : 2'h2);
            cmp({addr, doe[1] ? dout[63:32] : dout[31:0]}, {a, d});
            tick(3);
        end
        fop <= lbpc_pkg::OP_CPU_STORE;
        tick(1);
        fop <= lbpc_pkg::OP_CPU_LOAD;
        fork
            count_oe(4'h8, 6, c);
            begin
                tick(1);
                fop <= lbpc_pkg::OP_CPU_ALU;
            end
        join
        cmp(c, 1);
        // Refill without and with line crossing
        for (k = 0; k < 2; k++)
        begin
            {seen, bad} = 0;
            fpc <= $urandom;
            {imiss, icross} <= {1'b1, k[0]};
            tick(1);
            imiss <= 1'b0;
            count_oe(4'hC, 12, cnt[k]);
            cmp({seen, 32'(bad)}, {2'h3, 32'h0});
        end
        cmp({cnt[0] > 0, cnt[1]}, {1'b1, cnt[0] + 1});
        // Cache miss, prompt then slow memory, second time a load follows
        for (k = 0; k < 2; k++)
        begin
            a = $urandom;
            lat <= k ? 8'h14 : 8'h08;
            {aaddr, cmiss, fop} <= {a, 1'b1, lbpc_pkg::OP_CPU_LOAD};
            tick(1);
            fop <= k ? lbpc_pkg::OP_CPU_LOAD : lbpc_pkg::OP_CPU_ALU;
            tick(1);
            fop <= lbpc_pkg::OP_CPU_ALU;
            c = 0;
            #1;
            while (oe !== 4'hF && c < 12)
            begin
                tick(1);
                #1;
                c++;
            end
            cmp({oe, permit, addr}, {4'hF, 1'b0, a});
            tick(1);
            {cmiss, oint} <= 2'h1;
            tick(3);
            oint <= 1'b0;
            #1;
            cmp(a_wb, lbpc_pkg::ACT_HOLD);
            c = 0;
            while (alt !== 1'b1 && c < 40)
            begin
                tick(1);
                #1;
                c++;
            end
            cmp(addr, a ^ 32'h8);
            count_oe(4'hE, 8, c);
            cmp(c, k);
        end
        results;
    end
endmodule
